// ### logic/dtt_defs.vh
// constants for the memory thermal throttle block
`ifndef DTT_DEFS_VH
`define DTT_DEFS_VH
`define DTT_ROW_BITS 3
`define DTT_TALLY_W 16
`define DTT_CYC_HIT 2'h0
`define DTT_CYC_MISS 2'h1
`define DTT_CYC_EMPTY 2'h2
`define DTT_WT_HIT 4'h1
`define DTT_WT_EMPTY 4'h2
`define DTT_WT_MISS 4'h3
`define DTT_WINDOW_CYC 16'h0400
`define DTT_THROTTLE_PERIOD 4'h4
`define DTT_HOST_MHZ 40
`endif

// ### logic/dtt_gate.v
// duty-cycle gate that grants one slot in every few cycles while throttling
`default_nettype none
`include "dtt_defs.vh"
module dtt_gate #(
   parameter PERIOD = `DTT_THROTTLE_PERIOD
) (
   // clock and reset
   input wire clock,
   input wire nrst,
   // control
   input wire throttle,
   // slot enable pulse
   output reg slotOpen_q
);
   reg [3:0] cnt_q;
   always @(posedge clock) begin
      if (!nrst) begin
         cnt_q <= 4'h0;
         slotOpen_q <= 1'b1;
      end else if (!throttle) begin
         cnt_q <= 4'h0;
         slotOpen_q <= 1'b1;
      end else begin
         if (cnt_q == PERIOD - 4'h1) begin
            cnt_q <= 4'h0;
            slotOpen_q <= 1'b1;
         end else begin
            cnt_q <= cnt_q + 4'h1;
            slotOpen_q <= 1'b0;
         end
      end
   end
endmodule // dtt_gate
`default_nettype wire

// ### logic/dtt_throttle.v
// weighted per-row activity tally and over-temperature driven memory throttle
`default_nettype none
`include "dtt_defs.vh"
// Function
// - count 16-byte transfers per memory row
// - weight tally by hit, miss, empty type
// - over threshold in window reduces activity
// - throttle governs both reads and writes
// - low alert level raises interrupt/read throttle
// - alert read throttle applies to all rows
// - runs on the single host clock
module dtt_throttle #(
   parameter ROW_BITS = `DTT_ROW_BITS,
   parameter TALLY_W = `DTT_TALLY_W,
   parameter WINDOW_CYC = `DTT_WINDOW_CYC
) (
   // clock and reset
   input wire clock,
   input wire nrst,
   // transfer reports from the memory logic
   input wire xferValid,
   input wire [ROW_BITS-1:0] xferRow,
   input wire [1:0] xferCycType,
   // configuration
   input wire [TALLY_W-1:0] threshold,
   input wire alertIntEnable,
   input wire alertReadThrEnable,
   // over-temperature pin
   input wire over_temp_alert_n,
   // grants to the memory scheduler
   output reg readAllow_q,
   output reg writeAllow_q,
   output reg alertIrq_q,
   output reg activityThrottle_q
);
   localparam ROWS = 1 << ROW_BITS;
   // the window counter is 16 bits wide; longer windows are cut to it
   localparam integer WIN_LEN = WINDOW_CYC;
   localparam [15:0] WIN_LAST = WIN_LEN[15:0] - 16'h1;

   // -----------------------------
   // throttle states
   // -----------------------------
   // free: grants open; held: crossed in this window;
   // carried: crossed in the last window, not yet in this one
   localparam [1:0] ST_FREE = 2'h0;
   localparam [1:0] ST_HELD = 2'h1;
   localparam [1:0] ST_CARRIED = 2'h2;

   // -----------------------------
   // weight per cycle type
   // -----------------------------
   function [3:0] cycWeight;
      input [1:0] t;
      begin
         case (t)
            `DTT_CYC_HIT: cycWeight = `DTT_WT_HIT;
            `DTT_CYC_EMPTY: cycWeight = `DTT_WT_EMPTY;
            default: cycWeight = `DTT_WT_MISS;
         endcase
      end
   endfunction

   // -----------------------------
   // alert synchroniser
   // -----------------------------
   // the pin is asynchronous: only the second flop feeds any logic
   reg alertMeta_q;
   reg alertSync_q;
   always @(posedge clock) begin
      if (!nrst) begin
         alertMeta_q <= 1'b1;
         alertSync_q <= 1'b1;
      end else begin
         alertMeta_q <= over_temp_alert_n;
         alertSync_q <= alertMeta_q;
      end
   end
   wire alertActive = ~alertSync_q;

   // -----------------------------
   // monitoring window and tallies
   // -----------------------------
   reg [15:0] winCnt_q;
   reg [15:0] winCnt_d;
   reg [TALLY_W-1:0] tally_q [0:ROWS-1];
   reg [TALLY_W:0] addSum;
   reg [TALLY_W-1:0] addSat;
   reg hitNow;
   wire winEnd = (winCnt_q == WIN_LAST);
   integer i;

   always @* begin
      if (winEnd) begin
         winCnt_d = 16'h0;
      end else begin
         winCnt_d = winCnt_q + 16'h1;
      end
   end

   // saturate so a busy row cannot wrap back under the threshold
   always @* begin
      addSum = {1'b0, tally_q[xferRow]} + {{(TALLY_W-3){1'b0}}, cycWeight(xferCycType)};
      if (addSum[TALLY_W]) begin
         addSat = {TALLY_W{1'b1}};
      end else begin
         addSat = addSum[TALLY_W-1:0];
      end
      hitNow = xferValid && (addSat > threshold);
   end

   // -----------------------------
   // throttle state machine
   // -----------------------------
   reg [1:0] thrState_q;
   reg [1:0] thrState_d;
   reg activityThrottle_d;

   // a crossing keeps the throttle on through the following window, so
   // the release always waits for one whole clean window
   always @* begin
      thrState_d = thrState_q;
      case (thrState_q)
         ST_FREE: begin
            if (winEnd && hitNow) begin
               thrState_d = ST_CARRIED;
            end else if (hitNow) begin
               thrState_d = ST_HELD;
            end
         end
         ST_HELD: begin
            if (winEnd) begin
               thrState_d = ST_CARRIED;
            end
         end
         ST_CARRIED: begin
            if (winEnd && !hitNow) begin
               thrState_d = ST_FREE;
            end else if (!winEnd && hitNow) begin
               thrState_d = ST_HELD;
            end
         end
         default: begin
            thrState_d = ST_FREE;
         end
      endcase
      activityThrottle_d = (thrState_d != ST_FREE);
   end

   always @(posedge clock) begin
      if (!nrst) begin
         winCnt_q <= 16'h0;
         thrState_q <= ST_FREE;
         activityThrottle_q <= 1'b0;
      end else begin
         winCnt_q <= winCnt_d;
         thrState_q <= thrState_d;
         activityThrottle_q <= activityThrottle_d;
      end
   end

   // -----------------------------
   // row tallies
   // -----------------------------
   // a transfer on the window's last cycle is judged but not kept
   always @(posedge clock) begin
      if (!nrst || winEnd) begin
         for (i = 0; i < ROWS; i = i + 1) begin
            tally_q[i] <= {TALLY_W{1'b0}};
         end
      end else if (xferValid) begin
         tally_q[xferRow] <= addSat;
      end
   end

   // -----------------------------
   // slot gate and grants
   // -----------------------------
   wire readThrottle = activityThrottle_q | (alertActive & alertReadThrEnable);
   wire slotOpen;

   dtt_gate #(.PERIOD(`DTT_THROTTLE_PERIOD)) uGate (
      .clock(clock),
      .nrst(nrst),
      .throttle(readThrottle),
      .slotOpen_q(slotOpen)
   );

   // -----------------------------
   // grant registers
   // -----------------------------
   reg readAllow_d;
   reg writeAllow_d;
   reg alertIrq_d;

   // one grant line serves every row: the alert cannot tell which module is hot
   always @* begin
      if (readThrottle) begin
         readAllow_d = slotOpen;
      end else begin
         readAllow_d = 1'b1;
      end
      if (activityThrottle_q) begin
         writeAllow_d = slotOpen;
      end else begin
         writeAllow_d = 1'b1;
      end
      alertIrq_d = alertActive & alertIntEnable;
   end

   always @(posedge clock) begin
      if (!nrst) begin
         readAllow_q <= 1'b1;
         writeAllow_q <= 1'b1;
         alertIrq_q <= 1'b0;
      end else begin
         readAllow_q <= readAllow_d;
         writeAllow_q <= writeAllow_d;
         alertIrq_q <= alertIrq_d;
      end
   end
endmodule // dtt_throttle
`default_nettype wire

// ### testbench/dtt_sensor_model.sv
// two open-drain over-temperature sensors on one pulled-up line
`default_nettype none
module dtt_sensor_model (
   // hot flags and shared line
   input wire logic [1:0] hot,
   output wire logic alertN
);
   timeunit 1ns;
   timeprecision 1ns;
   assign alertN = hot == 2'h0;
endmodule // dtt_sensor_model
`default_nettype wire

// ### testbench/dtt_throttle_assertions.sv
// port checker for the thermal throttle
`default_nettype none
module dtt_throttle_assertions (
   // watched ports
   input wire logic clock,
   input wire logic nrst,
   input wire logic xferValid,
   input wire logic alertIntEnable,
   input wire logic alertReadThrEnable,
   input wire logic over_temp_alert_n,
   // watched grants
   input wire logic readAllow_q,
   input wire logic writeAllow_q,
   input wire logic alertIrq_q,
   input wire logic activityThrottle_q
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   property p_ion; (!over_temp_alert_n && alertIntEnable)[*3] |=> alertIrq_q; endproperty
   a_ion: assert property (p_ion) else $error("irq low");
   property p_ioff; over_temp_alert_n[*3] |=> !alertIrq_q; endproperty
   a_ioff: assert property (p_ioff) else $error("irq high");
   property p_rd; (!over_temp_alert_n && alertReadThrEnable)[*8]
      |-> !(readAllow_q && $past(readAllow_q)); endproperty
   a_rd: assert property (p_rd) else $error("reads free");
   property p_wfree; (!activityThrottle_q)[*4] |-> writeAllow_q; endproperty
   a_wfree: assert property (p_wfree) else $error("write held");
   property p_wthr; activityThrottle_q[*6] |-> !(writeAllow_q && $past(writeAllow_q)); endproperty
   a_wthr: assert property (p_wthr) else $error("writes free");
   // the raise lands one edge after the transfer that crossed
   property p_rise; $rose(activityThrottle_q) |-> $past(xferValid); endproperty
   a_rise: assert property (p_rise) else $error("raised idle");
   c_irq: cover property ($rose(alertIrq_q));
   c_act: cover property ($rose(activityThrottle_q));
   c_rel: cover property ($fell(activityThrottle_q));
endmodule // dtt_throttle_assertions
`default_nettype wire

// ### testbench/testbench.sv
// self-checking bench for the thermal throttle
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 0, nrst = 0, xferValid = 0, alertIntEnable = 0, alertReadThrEnable = 0;
   logic [2:0] xferRow = 3'h0;
   logic [1:0] xferCycType = 2'h0, hot = 2'h0;
   logic [15:0] threshold = 16'h0000;
   logic [7:0] rd, wr;
   wire over_temp_alert_n, readAllow_q, writeAllow_q, alertIrq_q, activityThrottle_q;
   int err_total = 0, num_checks = 0, hit, t[4], k, c, r;
   dtt_throttle #(.WINDOW_CYC(64)) dtt_throttle_inst (
      .clock(clock),
      .nrst(nrst),
      .xferValid(xferValid),
      .xferRow(xferRow),
      .xferCycType(xferCycType),
      .threshold(threshold),
      .alertIntEnable(alertIntEnable),
      .alertReadThrEnable(alertReadThrEnable),
      .over_temp_alert_n(over_temp_alert_n),
      .readAllow_q(readAllow_q),
      .writeAllow_q(writeAllow_q),
      .alertIrq_q(alertIrq_q),
      .activityThrottle_q(activityThrottle_q)
   );
   dtt_sensor_model dtt_sensor_model_inst (.hot(hot), .alertN(over_temp_alert_n));
   always #12.5 clock = ~clock;
   function int wt(int y);
      return y == 0 ? 1 : y == 2 ? 2 : 3;
   endfunction
   task chk(string n, logic [7:0] e, logic [7:0] s);
      num_checks++;
      if (s !== e) begin
         $display("unexpected %s expected %0h seen %0h", n, e, s);
         err_total++;
      end
   endtask
   task print_verdict;
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // grants over 8 cycles; an unknown grant poisons the count
   task cnt;
      rd = 0;
      wr = 0;
      repeat (8) begin
         @(negedge clock);
         rd += readAllow_q;
         wr += writeAllow_q;
      end
   endtask
   initial begin
      void'($urandom(32'hB47271F4));
      for (c = 0; c < 4; c++) begin
         if (c > 0) @(posedge clock);
         nrst <= 0;
         repeat (5) @(posedge clock);
         nrst <= 1;
         threshold <= 16'($urandom_range(20));
         t = '{default: 0};
         hit = 99;
         for (k = 0; k < 30; k++) begin
            @(posedge clock);
            r = $urandom_range(3);
            {xferValid, xferRow, xferCycType} <= {1'b1, 3'(r), 2'(c)};
            t[r] += wt(c);
            if (hit == 99 && t[r] > threshold) hit = k;
            @(negedge clock);
            chk("act", 8'(k > hit), 8'(activityThrottle_q));
         end
         @(posedge clock);
         xferValid <= 0;
         repeat (4) @(posedge clock);
         cnt;
         chk("wr", 8'(hit == 99 ? 8 : 2), wr);
         chk("rd", 8'(hit == 99 ? 8 : 2), rd);
         repeat (140) @(posedge clock);
         cnt;
         chk("lift", 8'h08, wr);
      end
      for (c = 0; c < 4; c++) begin
         @(posedge clock);
         {alertReadThrEnable, alertIntEnable} <= 2'(c);
         hot <= 2'($urandom_range(1, 3));
         repeat (6) @(posedge clock);
         cnt;
         chk("irq", 8'(c & 1), 8'(alertIrq_q));
         chk("rd", 8'(c > 1 ? 2 : 8), rd);
         chk("wr", 8'h08, wr);
         @(posedge clock);
         hot <= 2'h0;
         cnt;
         chk("irq", 8'h00, 8'(alertIrq_q));
      end
      print_verdict;
   end
endmodule // testbench
bind dtt_throttle dtt_throttle_assertions dtt_throttle_assertions_inst (
   .clock(clock),
   .nrst(nrst),
   .xferValid(xferValid),
   .alertIntEnable(alertIntEnable),
   .alertReadThrEnable(alertReadThrEnable),
   .over_temp_alert_n(over_temp_alert_n),
   .readAllow_q(readAllow_q),
   .writeAllow_q(writeAllow_q),
   .alertIrq_q(alertIrq_q),
   .activityThrottle_q(activityThrottle_q)
);
`default_nettype wire
